// ### bench/sopd_core_sva.sv
module sopd_chk #(
    parameter AW = 24
) (
    input wire logic          i_clk,
    input wire logic          i_reset,
    input wire logic          i_psel,
    input wire logic          i_penable,
    input wire logic          i_pwrite,
    input wire logic [7:0]    i_paddr,
    input wire logic [31:0]   o_prdata,
    input wire logic          o_pready,
    input wire logic          o_pslverr,
    input wire logic          o_mem_req,
    input wire logic          o_mem_we,
    input wire logic [AW-1:0] o_mem_addr,
    input wire logic [7:0]    o_mem_wdata,
    input wire logic          i_mem_ack,
    input wire logic          o_busy,
    input wire logic          o_priv_trap
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_reset);
    sequence s_setup;
        i_psel && !i_penable;
    endsequence
    sequence s_pending;
        o_mem_req && !i_mem_ack;
    endsequence
    a_reset_quiet: assert property ($fell(i_reset) |-> !o_busy && !o_mem_req && !o_pready)
        else $error("outputs active after reset");
    a_pready_wait: assert property (s_setup |=> o_pready)
        else $error("no answer one cycle after setup");
    a_pready_gated: assert property (o_pready |-> i_psel && i_penable && !$past(o_pready))
        else $error("answer outside access phase");
    a_slverr_map: assert property (o_pready |-> o_pslverr == (i_paddr > 8'h28))
        else $error("error flag does not follow address");
    a_unmapped_zero: assert property (o_pready && !i_pwrite && i_paddr > 8'h28 |-> o_prdata == 0)
        else $error("unmapped read not zero");
    a_req_hold: assert property (s_pending |=> o_mem_req && $stable(o_mem_addr)
        && $stable(o_mem_we) && $stable(o_mem_wdata))
        else $error("memory request changed before answer");
    a_req_in_op: assert property (o_mem_req |-> o_busy)
        else $error("memory request while idle");
    a_busy_ends: assert property ($rose(o_busy) |-> ##[1:400] !o_busy)
        else $error("string operation does not end");
endmodule
bind sopd_core sopd_chk #(.AW(AW)) chk_u (.*);

// ### bench/sopd_mem_model.sv
module sopd_mem_model #(
    parameter int AW = 24
) (
    // Clock and mode
    input  wire logic          i_clk,
    input  wire logic          i_slow,
    // Request from the block
    input  wire logic          i_req,
    input  wire logic          i_we,
    input  wire logic [AW-1:0] i_addr,
    input  wire logic [7:0]    i_wdata,
    // Answer
    output logic               o_ack,
    output logic [7:0]         o_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0]    wait_q = 4'h0;
    logic [AW-1:0] last_waddr = '0;
    logic [7:0]    last_wdata = 8'h00;
    initial o_ack = 1'b0;
    initial o_rdata = 8'h00;
    // ----------------------------------------
    // Byte store: read data is the address mixed with a constant
    // ----------------------------------------
    always @(posedge i_clk) begin
        o_ack <= 1'b0;
        // Bus not valid outside an answer, so keep it toggling
        o_rdata <= ~o_rdata;
        if (i_req && !o_ack) begin
            if (wait_q == (i_slow ? 4'h3 : 4'h0)) begin
                o_ack <= 1'b1;
                wait_q <= 4'h0;
                if (!i_we) begin
                    o_rdata <= i_addr[7:0] ^ 8'h5A;
                end else begin
                    last_waddr <= i_addr;
                    last_wdata <= i_wdata;
                end
            end else begin
                wait_q <= wait_q + 4'h1;
            end
        end
    end
endmodule

// ### bench/string_op_and_privilege_decode_tb.sv
`include "sopd_consts.vh"
module string_op_and_privilege_decode_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_clk = 0, i_reset = 1, i_psel = 0, i_penable = 0, i_pwrite = 0, slow = 0;
    logic [7:0] i_paddr = 8'h00;
    logic [31:0] i_pwdata = 32'h0, o_prdata, rd;
    logic o_pready, o_pslverr, o_mem_req, o_mem_we, i_mem_ack, o_busy, o_priv_trap, err;
    logic [23:0] o_mem_addr;
    logic [7:0] o_mem_wdata, i_mem_rdata;
    int failures = 0, num_checks = 0;
    logic [35:0] dec_t [16] = '{36'h1_80000092, 36'h1_800000E2, 36'h0_80000002,
        36'h1_80000093, 36'h0_80000013, 36'h1_80000104, 36'h0_80000004, 36'h1_80000305,
        36'h0_80000005, 36'h1_80000006, 36'h2_80000006, 36'h1_80000007, 36'h1_80000008,
        36'h2_80000007, 36'h2_80000008, 36'h2_80000092};
    initial forever #2 i_clk = ~i_clk;
    sopd_core #(.AW(24)) dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_ce(1'b1),
        .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
        .i_pwdata(i_pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
        .o_pslverr(o_pslverr), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
        .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata), .i_mem_ack(i_mem_ack),
        .i_mem_rdata(i_mem_rdata), .o_busy(o_busy), .o_priv_trap(o_priv_trap));
    sopd_mem_model #(.AW(24)) mem_u (.i_clk(i_clk), .i_slow(slow), .i_req(o_mem_req),
        .i_we(o_mem_we), .i_addr(o_mem_addr), .i_wdata(o_mem_wdata), .o_ack(i_mem_ack),
        .o_rdata(i_mem_rdata));
    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task conclude();
        $display("checks %0d, mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge i_clk);
        i_psel <= 1'b1; i_penable <= 1'b0; i_pwrite <= w; i_paddr <= a; i_pwdata <= d;
        @(posedge i_clk);
        i_penable <= 1'b1;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_pready !== 1'b1 && n < 20);
        rd = o_prdata;
        err = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
        if (n >= 20) begin failures++; conclude(); end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    // Runs one string operation and waits, bounded, for it to finish
    task str_op(input logic [31:0] cnt, p1, p2, cv, input logic [7:0] ctl);
        int n;
        n = 0;
        wr(`SOPD_A_COUNT, cnt); wr(`SOPD_A_PTR1, p1);
        wr(`SOPD_A_PTR2, p2); wr(`SOPD_A_CMPVAL, cv); wr(`SOPD_A_CTRL, {24'h0, ctl});
        repeat (2) @(posedge i_clk);
        while (o_busy !== 1'b0 && n < 2000) begin @(posedge i_clk); n++; end
        if (n >= 2000) begin failures++; conclude(); end
    endtask
    task decode(input logic [31:0] word);
        wr(`SOPD_A_DECODE, word);
        repeat (3) @(posedge i_clk);
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task t_move_back();
        slow <= 1'b1;
        str_op(32'h3, 32'h40, 32'h80, 32'h0, 8'h03);
        slow <= 1'b0;
        rdc(`SOPD_A_PTR1, 32'h3D);
        rdc(`SOPD_A_PTR2, 32'h7D);
        rdc(`SOPD_A_COUNT, 32'h0);
        chk({8'h0, mem_u.last_waddr}, 32'h7E);
        chk({24'h0, mem_u.last_wdata}, 32'h64);
    endtask
    task t_zero_count();
        str_op(32'h0, 32'h55, 32'h66, 32'h0, 8'h01);
        rdc(`SOPD_A_PTR1, 32'h55);
        rdc(`SOPD_A_PTR2, 32'h66);
    endtask
    task t_match_ends();
        // Until: 4th element equals the value, so the count stops short
        str_op(32'h8, 32'h10, 32'h0, 32'h49, 8'h25);
        rdc(`SOPD_A_COUNT, 32'h4);
        rdc(`SOPD_A_STATUS, 32'h4);
        // While: 2nd element differs from the value
        str_op(32'h8, 32'h20, 32'h0, 32'h7A, 8'h29);
        rdc(`SOPD_A_COUNT, 32'h6);
        rdc(`SOPD_A_STATUS, 32'h4);
    endtask
    task t_translate();
        // Table holds the inverse of its index; base offset 1 shifts it
        wr(`SOPD_A_TBASE, 32'h1);
        str_op(32'h8, 32'h10, 32'h0, 32'hB6, 8'h65);
        rdc(`SOPD_A_COUNT, 32'h5);
        rdc(`SOPD_A_STATUS, 32'h4);
        // First pair equal after translation, second differs
        str_op(32'h8, 32'h10, 32'hEE, 32'h0, 8'h51);
        rdc(`SOPD_A_COUNT, 32'h6);
        rdc(`SOPD_A_STATUS, 32'h8);
    endtask
    task t_priv();
        for (int i = 0; i < 16; i++) begin
            wr(`SOPD_A_CTRL, {24'h0, dec_t[i][33], 7'h0});
            decode(dec_t[i][31:0]);
            chk({31'h0, o_priv_trap}, {31'h0, dec_t[i][32]});
        end
        wr(`SOPD_A_RESULT, 32'hA);
        decode(32'h80000006);
        rdc(`SOPD_A_CFG, 32'hA);
        wr(`SOPD_A_CTRL, 32'h0);
        wr(`SOPD_A_RESULT, 32'h5);
        decode(32'h80000006);
        rdc(`SOPD_A_CFG, 32'hA);
    endtask
    task t_acb();
        wr(`SOPD_A_RESULT, 32'h5);
        wr(`SOPD_A_DISP, 32'h40);
        decode(32'h8000B001);
        rdc(`SOPD_A_RESULT, 32'h0);
        rdc(`SOPD_A_DISP, 32'h0);
        wr(`SOPD_A_RESULT, 32'h3);
        wr(`SOPD_A_DISP, 32'h40);
        decode(32'h80008001);
        rdc(`SOPD_A_RESULT, 32'hFFFFFFFB);
        rdc(`SOPD_A_DISP, 32'h40);
        decode(32'h80000009);
        rdc(`SOPD_A_DISP, 32'h0);
        rdc(`SOPD_A_RESULT, 32'h1);
        apb(1'b0, 8'h2C, 32'h0);
        chk({err, rd[30:0]}, 32'h80000000);
    endtask
    initial begin
        // Translation table preset to the inverse of its index
        for (int k = 0; k < 256; k++) dut_u.u_xlat.mem[k] = 8'hFF ^ 8'(k);
        repeat (10) @(posedge i_clk);
        i_reset <= 1'b0;
        t_move_back();
        t_zero_count();
        t_match_ends();
        t_translate();
        t_priv();
        t_acb();
        conclude();
    end
endmodule

// ### src/sopd_consts.vh
`ifndef SOPD_CONSTS_VH
`define SOPD_CONSTS_VH
// ----------------------------------------
// APB register map (byte addresses)
// ----------------------------------------
`define SOPD_A_CTRL     8'h00
`define SOPD_A_STATUS   8'h04
`define SOPD_A_COUNT    8'h08
`define SOPD_A_PTR1     8'h0C
`define SOPD_A_PTR2     8'h10
`define SOPD_A_TBASE    8'h14
`define SOPD_A_CMPVAL   8'h18
`define SOPD_A_DECODE   8'h1C
`define SOPD_A_RESULT   8'h20
`define SOPD_A_DISP     8'h24
`define SOPD_A_CFG      8'h28
// ----------------------------------------
// Control fields
// ----------------------------------------
`define SOPD_C_START    0
`define SOPD_C_BACK     1
`define SOPD_C_UNTIL    2
`define SOPD_C_WHILE    3
`define SOPD_C_OP_LO    4
`define SOPD_C_OP_HI    5
`define SOPD_C_TRANS    6
`define SOPD_C_SUPER    7
// ----------------------------------------
// String operations
// ----------------------------------------
`define SOPD_OP_MOVE    2'h0
`define SOPD_OP_CMP     2'h1
`define SOPD_OP_SKIP    2'h2
// ----------------------------------------
// Decode opcodes
// ----------------------------------------
`define SOPD_D_ACB      4'h1
`define SOPD_D_LPR      4'h2
`define SOPD_D_SPR      4'h3
`define SOPD_D_BIS      4'h4
`define SOPD_D_BIC      4'h5
`define SOPD_D_SET_CONFIGURATION   4'h6
`define SOPD_D_RETURN_FROM_TRAP     4'h7
`define SOPD_D_RETURN_FROM_INTERRUPT     4'h8
`define SOPD_D_DIA      4'h9
`define SOPD_AREG_PSR   4'h9
`define SOPD_AREG_INTB  4'hE
`define SOPD_LEN_BYTE   2'h0
`define SOPD_DIA_LEN    32'h00000001
`endif

// ### src/sopd_core.v
`include "sopd_consts.vh"
module sopd_core #(
    parameter AW = 24
) (
    // Clock and reset
    input  wire          i_clk,
    input  wire          i_reset,
    input  wire          i_ce,
    // APB slave
    input  wire          i_psel,
    input  wire          i_penable,
    input  wire          i_pwrite,
    input  wire [7:0]    i_paddr,
    input  wire [31:0]   i_pwdata,
    output reg  [31:0]   o_prdata,
    output reg           o_pready,
    output reg           o_pslverr,
    // Operand memory
    output reg           o_mem_req,
    output reg           o_mem_we,
    output reg  [AW-1:0] o_mem_addr,
    output reg  [7:0]    o_mem_wdata,
    input  wire          i_mem_ack,
    input  wire [7:0]    i_mem_rdata,
    // Status
    output reg           o_busy,
    output reg           o_priv_trap
);
    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam S_IDLE = 6'b000001;
    localparam S_RD1  = 6'b000010;
    localparam S_XL   = 6'b000100;
    localparam S_RD2  = 6'b001000;
    localparam S_WR   = 6'b010000;
    localparam S_STEP = 6'b100000;

    reg [5:0]    st_q;
    reg [31:0]   ctrl_q;
    reg [31:0]   cnt_q;
    reg [AW-1:0] p1_q;
    reg [AW-1:0] p2_q;
    reg [AW-1:0] tb_q;
    reg [7:0]    cmpv_q;
    reg [31:0]   dec_q;
    reg [31:0]   res_q;
    reg [31:0]   disp_q;
    reg [31:0]   cfg_q;
    reg [7:0]    e1_q;
    reg [7:0]    e1x_q;
    reg          done_m_q;
    reg          neq_q;
    reg          cfg_we;
    wire [7:0]   xl_rdata;

    wire acc = i_psel & i_penable & o_pready;
    wire wr  = acc & i_pwrite;
    wire [1:0] op    = ctrl_q[`SOPD_C_OP_HI:`SOPD_C_OP_LO];
    wire       trans = ctrl_q[`SOPD_C_TRANS];
    wire       sup   = ctrl_q[`SOPD_C_SUPER];

    // ----------------------------------------
    // Translation table, base from R3
    // ----------------------------------------
    // Index from answer data, so table output is ready in S_XL
    wire [7:0] xl_byte = (st_q == S_RD1) ? i_mem_rdata : e1_q;
    wire [7:0] xl_idx  = xl_byte + tb_q[7:0]; // Wraps within the table
    sopd_xlat_mem #(.AW(8)) u_xlat (
        .i_clk   (i_clk),
        .i_ce    (i_ce),
        .i_we    (1'b0),
        .i_waddr (8'h00),
        .i_wdata (8'h00),
        .i_raddr (xl_idx),
        .o_rdata (xl_rdata)
    );

    // Value that match tests use: translated only on translated ops
    wire [7:0] mval  = trans ? e1x_q : e1_q;
    wire       m_end = (ctrl_q[`SOPD_C_UNTIL] & (mval == cmpv_q))
                     | (ctrl_q[`SOPD_C_WHILE] & (mval != cmpv_q));

    // ----------------------------------------
    // Decoder for privileged and special ops
    // ----------------------------------------
    wire [3:0]  d_op   = dec_q[3:0];
    wire [3:0]  d_areg = dec_q[7:4];
    wire [1:0]  d_len  = dec_q[9:8];
    wire [3:0]  d_qk   = dec_q[15:12];
    reg         priv;
    reg         cfgld;
    reg  [31:0] sum;
    always @* begin
        priv  = 1'b0;
        cfgld = 1'b0;
        sum   = res_q + {{28{d_qk[3]}}, d_qk};
        case (d_op)
            `SOPD_D_LPR, `SOPD_D_SPR:
                priv = (d_areg == `SOPD_AREG_PSR) | (d_areg == `SOPD_AREG_INTB);
            `SOPD_D_BIS, `SOPD_D_BIC:
                priv = (d_len != `SOPD_LEN_BYTE);
            `SOPD_D_SET_CONFIGURATION: begin
                priv  = 1'b1;
                cfgld = sup;
            end
            `SOPD_D_RETURN_FROM_TRAP, `SOPD_D_RETURN_FROM_INTERRUPT:
                priv = 1'b1;
            default: priv = 1'b0;
        endcase
    end
    always @* begin
        cfg_we = wr & (i_paddr == `SOPD_A_DECODE) & (i_pwdata[3:0] == `SOPD_D_SET_CONFIGURATION)
               & sup & ~o_busy;
    end

    // ----------------------------------------
    // APB and sequencer
    // ----------------------------------------
    always @(posedge i_clk) begin
        if (i_reset) begin
            st_q        <= S_IDLE;
            ctrl_q      <= 32'h00000000;
            cnt_q       <= 32'h00000000;
            p1_q        <= {AW{1'b0}};
            p2_q        <= {AW{1'b0}};
            tb_q        <= {AW{1'b0}};
            cmpv_q      <= 8'h00;
            dec_q       <= 32'h00000000;
            res_q       <= 32'h00000000;
            disp_q      <= 32'h00000000;
            cfg_q       <= 32'h00000000;
            e1_q        <= 8'h00;
            e1x_q       <= 8'h00;
            done_m_q    <= 1'b0;
            neq_q       <= 1'b0;
            o_prdata    <= 32'h00000000;
            o_pready    <= 1'b0;
            o_pslverr   <= 1'b0;
            o_mem_req   <= 1'b0;
            o_mem_we    <= 1'b0;
            o_mem_addr  <= {AW{1'b0}};
            o_mem_wdata <= 8'h00;
            o_busy      <= 1'b0;
            o_priv_trap <= 1'b0;
        end else if (i_ce) begin
            // No wait state: ready in the cycle after setup
            o_pready  <= i_psel & ~i_penable;
            o_pslverr <= 1'b0;
            if (i_psel & ~i_penable & ~i_pwrite) begin
                case (i_paddr)
                    `SOPD_A_CTRL:   o_prdata <= ctrl_q;
                    `SOPD_A_STATUS: o_prdata <= {28'h0000000, neq_q, done_m_q,
                                                 o_priv_trap, o_busy};
                    `SOPD_A_COUNT:  o_prdata <= cnt_q;
                    `SOPD_A_PTR1:   o_prdata <= {{(32-AW){1'b0}}, p1_q};
                    `SOPD_A_PTR2:   o_prdata <= {{(32-AW){1'b0}}, p2_q};
                    `SOPD_A_TBASE:  o_prdata <= {{(32-AW){1'b0}}, tb_q};
                    `SOPD_A_CMPVAL: o_prdata <= {24'h000000, cmpv_q};
                    `SOPD_A_DECODE: o_prdata <= dec_q;
                    `SOPD_A_RESULT: o_prdata <= res_q;
                    `SOPD_A_DISP:   o_prdata <= disp_q;
                    `SOPD_A_CFG:    o_prdata <= cfg_q;
                    default:        o_prdata <= 32'h00000000;
                endcase
            end
            if (i_psel & ~i_penable & (i_paddr > `SOPD_A_CFG)) begin
                o_pslverr <= 1'b1;
            end
            // Registers are frozen while a string op runs, so writes then are dropped
            if (wr & ~o_busy) begin
                case (i_paddr)
                    `SOPD_A_CTRL:   ctrl_q <= i_pwdata;
                    `SOPD_A_COUNT:  cnt_q  <= i_pwdata;
                    `SOPD_A_PTR1:   p1_q   <= i_pwdata[AW-1:0];
                    `SOPD_A_PTR2:   p2_q   <= i_pwdata[AW-1:0];
                    `SOPD_A_TBASE:  tb_q   <= i_pwdata[AW-1:0];
                    `SOPD_A_CMPVAL: cmpv_q <= i_pwdata[7:0];
                    `SOPD_A_RESULT: res_q  <= i_pwdata;
                    `SOPD_A_DISP:   disp_q <= i_pwdata;
                    `SOPD_A_DECODE: dec_q  <= i_pwdata;
                    default:        ctrl_q <= ctrl_q;
                endcase
            end
            if (cfg_we) begin
                cfg_q <= res_q;
            end
            // Decode evaluation one cycle after the decode word lands
            if (wr & (i_paddr == `SOPD_A_DECODE)) begin
                o_priv_trap <= 1'b0;
            end else if (dec_q[31]) begin
                dec_q[31]   <= 1'b0;
                o_priv_trap <= priv & ~sup;
                if (d_op == `SOPD_D_ACB) begin
                    res_q  <= sum;
                    disp_q <= (sum != 32'h00000000) ? disp_q : 32'h00000000;
                end else if (d_op == `SOPD_D_DIA) begin
                    disp_q <= 32'h00000000;
                    res_q  <= `SOPD_DIA_LEN;
                end
                if (cfgld) begin
                    cfg_q <= res_q;
                end
            end
            case (st_q)
                S_IDLE: begin
                    if (wr & ~o_busy & (i_paddr == `SOPD_A_CTRL) & i_pwdata[`SOPD_C_START]) begin
                        o_busy   <= 1'b1;
                        done_m_q <= 1'b0;
                        neq_q    <= 1'b0;
                        if (cnt_q == 32'h00000000) begin
                            o_busy <= 1'b0;
                        end else begin
                            st_q       <= S_RD1;
                            o_mem_req  <= 1'b1;
                            o_mem_we   <= 1'b0;
                            o_mem_addr <= p1_q;
                        end
                    end
                end
                S_RD1: if (i_mem_ack) begin
                    o_mem_req <= 1'b0;
                    e1_q      <= i_mem_rdata;
                    st_q      <= trans ? S_XL : S_STEP;
                    if (op == `SOPD_OP_CMP) begin
                        st_q       <= S_RD2;
                        o_mem_req  <= ~trans;
                        o_mem_addr <= p2_q;
                    end else if (op == `SOPD_OP_MOVE & ~trans) begin
                        st_q        <= S_WR;
                        o_mem_req   <= 1'b1;
                        o_mem_we    <= 1'b1;
                        o_mem_addr  <= p2_q;
                        o_mem_wdata <= i_mem_rdata;
                    end
                end
                S_XL: begin
                    e1x_q <= xl_rdata;
                    st_q  <= S_STEP;
                    if (op == `SOPD_OP_MOVE) begin
                        st_q        <= S_WR;
                        o_mem_req   <= 1'b1;
                        o_mem_we    <= 1'b1;
                        o_mem_addr  <= p2_q;
                        o_mem_wdata <= xl_rdata;
                    end else if (op == `SOPD_OP_CMP) begin
                        st_q       <= S_RD2;
                        o_mem_req  <= 1'b1;
                        o_mem_addr <= p2_q;
                    end
                end
                S_RD2: begin
                    if (trans & ~o_mem_req) begin
                        st_q <= S_XL; // translate first, then fetch second
                    end else if (i_mem_ack) begin
                        o_mem_req <= 1'b0;
                        st_q      <= S_STEP;
                        neq_q     <= ((trans ? e1x_q : e1_q) != i_mem_rdata);
                    end
                end
                S_WR: if (i_mem_ack) begin
                    o_mem_req <= 1'b0;
                    o_mem_we  <= 1'b0;
                    st_q      <= S_STEP;
                end
                S_STEP: begin
                    if (ctrl_q[`SOPD_C_BACK]) begin
                        p1_q <= p1_q - 1'b1;
                        p2_q <= p2_q - 1'b1;
                    end else begin
                        p1_q <= p1_q + 1'b1;
                        p2_q <= p2_q + 1'b1;
                    end
                    cnt_q <= cnt_q - 32'h00000001;
                    if ((cnt_q == 32'h00000001) | m_end | neq_q) begin
                        st_q     <= S_IDLE;
                        o_busy   <= 1'b0;
                        done_m_q <= m_end;
                    end else begin
                        st_q       <= S_RD1;
                        o_mem_req  <= 1'b1;
                        o_mem_addr <= ctrl_q[`SOPD_C_BACK] ? p1_q - 1'b1 : p1_q + 1'b1;
                    end
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end
endmodule

// ### src/sopd_xlat_mem.v
module sopd_xlat_mem #(
    parameter AW = 8
) (
    // Clock
    input  wire          i_clk,
    input  wire          i_ce,
    // Write port
    input  wire          i_we,
    input  wire [AW-1:0] i_waddr,
    input  wire [7:0]    i_wdata,
    // Read port
    input  wire [AW-1:0] i_raddr,
    output reg  [7:0]    o_rdata
);
    reg [7:0] mem [0:(1<<AW)-1];
    always @(posedge i_clk) begin
        if (i_ce) begin
            if (i_we) begin
                mem[i_waddr] <= i_wdata;
            end
            o_rdata <= mem[i_raddr];
        end
    end
endmodule
